// [design/lwc_top.sv]
// Word capture and generation port: register file, bank, link sequencer and link side logic.
//
// The implementer's own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
module lwc_top (
  input  wire logic                  clk,
  input  wire logic                  rstn,
  input  wire logic                  lclk,
  input  wire logic                  strap_gen,
  input  wire lwc_pkg::lwc_req_s     req,
  output logic [lwc_pkg::DW-1:0]     rdata,
  input  wire lwc_pkg::lwc_pin_in_s  pin_i,
  output lwc_pkg::lwc_pin_out_s      pin_o
);
  import lwc_pkg::*;

  // ****************************************
  // State of the system clock domain
  // ****************************************
  typedef struct packed {
    logic           strap1, strap2;
    logic           en, tp, hen, trans;
    logic [EAW-1:0] esel;
    logic [EAW:0]   chain;
    logic [BAW:0]   wptr, rptr;
    logic           ovr, tdone;
    logic [DW-1:0]  rdata;
    lwc_gen_e       gst;
    logic [EAW-1:0] ent;
    logic [7:0]     idx, rep;
    logic [15:0]    dly;
    logic [DW-1:0]  gw;
    logic           greq_t, ga1, ga2, ga_seen;
    logic           cc1, cc2, cc_seen, cack_t;
    logic           lo1, lo2, lo_seen;
  } lwc_sys_s;

  // ****************************************
  // State of the link clock domain
  // ****************************************
  typedef struct packed {
    logic          gen1, gen2, en1, en2, tp1, tp2, hen1, hen2, full1, full2;
    logic [DW-1:0] d1, d2;
    logic          q1, q2, h1, h2;
    logic          rq1, rq2, rq_seen, ca1, ca2, ca_seen;
    logic          busy, cap_t, lost_t;
    logic [DW-1:0] cw, tpc, word, dout;
    logic          have, ack_t, pclk, qual, oe, hold, hoe;
  } lwc_lnk_s;

  lwc_sys_s       s, next_s;
  lwc_lnk_s       l, next_l;
  logic [DW-1:0]  bank [BDEPTH];
  lwc_ent_s       tab [ENTRIES];
  logic           bank_we;
  logic [BAW-1:0] bank_wa;
  logic [DW-1:0]  bank_wd;
  logic           ent_we;
  lwc_ent_s       ent_wd;
  logic [1:0]     lrst;

  // Bank fill level and flags.
  logic [BAW:0]   cnt;
  logic           full, empty;
  assign cnt   = s.wptr - s.rptr;
  assign full  = cnt[BAW];
  assign empty = (s.wptr == s.rptr);

  // ****************************************
  // System domain next state
  // ****************************************
  always_comb begin
    lwc_ent_s e;
    lwc_ent_s en_next;
    logic     trig;
    e       = tab[s.esel];
    en_next = tab[s.ent + 6'h01];
    trig    = 1'b0;
    next_s  = s;
    bank_we = 1'b0;
    bank_wa = s.wptr[BAW-1:0];
    bank_wd = req.wdata;
    ent_we  = 1'b0;
    ent_wd  = e;
    next_s.rdata  = '0;
    next_s.strap1 = strap_gen;
    next_s.strap2 = s.strap1;
    next_s.ga1    = l.ack_t;
    next_s.ga2    = s.ga1;
    next_s.cc1    = l.cap_t;
    next_s.cc2    = s.cc1;
    next_s.lo1    = l.lost_t;
    next_s.lo2    = s.lo1;
    // Register writes.
    if (req.wr) begin
      case (req.addr)
        OFS_CTRL: begin
          next_s.en    = req.wdata[CTRL_EN];
          next_s.tp    = req.wdata[CTRL_TP];
          next_s.hen   = req.wdata[CTRL_HOLD];
          next_s.trans = req.wdata[CTRL_TRANS];
          trig         = req.wdata[CTRL_TRIG];
          if (req.wdata[CTRL_CLR]) begin
            next_s.wptr  = '0;
            next_s.rptr  = '0;
            next_s.tdone = 1'b0;
          end
        end
        OFS_STATUS: if (req.wdata[ST_OVR]) next_s.ovr = 1'b0;
        OFS_DATA: if (s.strap2 && !full) begin
          bank_we     = 1'b1;
          next_s.wptr = s.wptr + 9'h001;
        end
        OFS_ESEL:  next_s.esel = req.wdata[EAW-1:0];
        OFS_EBASE: begin ent_we = 1'b1; ent_wd.base = req.wdata[BAW-1:0]; end
        OFS_ELEN:  begin ent_we = 1'b1; ent_wd.len = req.wdata[7:0]; end
        OFS_EDLY:  begin ent_we = 1'b1; ent_wd.dly = req.wdata[15:0]; end
        OFS_EREP:  begin ent_we = 1'b1; ent_wd.rep = req.wdata[7:0]; end
        OFS_CHAIN: next_s.chain = (req.wdata > 32'h00000040) ? 7'h40 : req.wdata[EAW:0];
        default: ;
      endcase
    end
    // Register reads; a data read drains the captured stream.
    if (req.rd) begin
      case (req.addr)
        OFS_CTRL:   next_s.rdata = {28'h0000000, s.trans, s.hen, s.tp, s.en};
        OFS_STATUS: next_s.rdata = {15'h0000, cnt, 3'h0, s.ovr, empty, full,
                                    (s.gst != GS_IDLE), s.strap2};
        OFS_DATA: if (!s.strap2 && !empty) begin
          next_s.rdata = bank[s.rptr[BAW-1:0]];
          next_s.rptr  = s.rptr + 9'h001;
        end
        OFS_ESEL:   next_s.rdata = {26'h0000000, s.esel};
        OFS_EBASE:  next_s.rdata = {24'h000000, e.base};
        OFS_ELEN:   next_s.rdata = {24'h000000, e.len};
        OFS_EDLY:   next_s.rdata = {16'h0000, e.dly};
        OFS_EREP:   next_s.rdata = {24'h000000, e.rep};
        OFS_CHAIN:  next_s.rdata = {25'h0000000, s.chain};
        default:    next_s.rdata = '0;
      endcase
    end
    // Captured word arrives from the link side; bank is FIFO or one-shot record.
    if (s.cc2 != s.cc_seen) begin
      next_s.cc_seen = s.cc2;
      next_s.cack_t  = ~s.cack_t;
      if (!full && !s.tdone) begin
        bank_we     = 1'b1;
        bank_wa     = next_s.wptr[BAW-1:0];
        bank_wd     = l.cw;
        next_s.wptr = next_s.wptr + 9'h001;
        if (s.trans && (cnt == 9'h0ff)) next_s.tdone = 1'b1;
      end else begin
        next_s.ovr = 1'b1;
      end
    end
    // Lost words on the link also set the sticky overrun, winning over a clear.
    if (s.lo2 != s.lo_seen) begin
      next_s.lo_seen = s.lo2;
      next_s.ovr     = 1'b1;
    end
    // Linked-list generation sequencer.
    case (s.gst)
      GS_IDLE: if (trig && s.strap2 && s.en && (s.chain != 7'h00)) begin
        next_s.ent = '0;
        next_s.idx = '0;
        next_s.rep = tab[0].rep;
        next_s.dly = tab[0].dly;
        next_s.gst = GS_DLY;
      end
      GS_DLY: begin
        if (!s.en) next_s.gst = GS_IDLE;
        else if (s.dly == 16'h0000) next_s.gst = GS_SEND;
        else next_s.dly = s.dly - 16'h0001;
      end
      GS_SEND: begin
        next_s.gw     = bank[tab[s.ent].base + s.idx];
        next_s.greq_t = ~s.greq_t;
        next_s.gst    = GS_ACK;
      end
      GS_ACK: if (s.ga2 != s.ga_seen) begin
        next_s.ga_seen = s.ga2;
        if (!s.en) begin
          next_s.gst = GS_IDLE;
        end else if (s.idx != tab[s.ent].len) begin
          next_s.idx = s.idx + 8'h01;
          next_s.gst = GS_SEND;
        end else if (s.rep != 8'h00) begin
          next_s.rep = s.rep - 8'h01;
          next_s.idx = '0;
          next_s.gst = GS_SEND;
        end else if (({1'b0, s.ent} + 7'h01) != s.chain) begin
          next_s.ent = s.ent + 6'h01;
          next_s.idx = '0;
          next_s.rep = en_next.rep;
          next_s.dly = en_next.dly;
          next_s.gst = GS_DLY;
        end else begin
          next_s.gst = GS_IDLE;
        end
      end
      default: next_s.gst = GS_IDLE;
    endcase
  end

  // Registers of the system domain.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      s     <= '0;
      s.gst <= GS_IDLE;
    end else begin
      s <= next_s;
    end
  end

  // Bank and entry table storage.
  always_ff @(posedge clk) begin
    if (bank_we) bank[bank_wa] <= bank_wd;
    if (ent_we) tab[s.esel] <= ent_wd;
  end

  assign rdata = s.rdata;

  // ****************************************
  // Link domain next state
  // ****************************************
  always_comb begin
    logic free;
    next_l       = l;
    next_l.gen1  = s.strap2;
    next_l.gen2  = l.gen1;
    next_l.en1   = s.en;
    next_l.en2   = l.en1;
    next_l.tp1   = s.tp;
    next_l.tp2   = l.tp1;
    next_l.hen1  = s.hen;
    next_l.hen2  = l.hen1;
    next_l.full1 = full | s.tdone;
    next_l.full2 = l.full1;
    next_l.d1    = pin_i.data;
    next_l.d2    = l.d1;
    next_l.q1    = pin_i.qual;
    next_l.q2    = l.q1;
    next_l.h1    = pin_i.hold;
    next_l.h2    = l.h1;
    next_l.rq1   = s.greq_t;
    next_l.rq2   = l.rq1;
    next_l.ca1   = s.cack_t;
    next_l.ca2   = l.ca1;
    next_l.oe    = l.gen2;
    next_l.hoe   = !l.gen2;
    free         = !l.busy;
    if (!l.gen2) begin
      // Capture: one word in flight toward the bank at a time.
      next_l.pclk = 1'b0;
      next_l.qual = 1'b0;
      if (l.ca2 != l.ca_seen) begin
        next_l.ca_seen = l.ca2;
        next_l.busy    = 1'b0;
        free           = 1'b1;
      end
      if (l.en2 && l.q2) begin
        if (free) begin
          next_l.cw    = l.tp2 ? l.tpc : l.d2;
          next_l.tpc   = l.tpc + 32'h00000001;
          next_l.cap_t = ~l.cap_t;
          next_l.busy  = 1'b1;
        end else begin
          next_l.lost_t = ~l.lost_t;
        end
      end
      next_l.hold = l.hen2 & (next_l.busy | l.full2);
    end else begin
      // Generation: port clock is half the link clock; data change before its rise.
      next_l.hold = 1'b0;
      next_l.pclk = ~l.pclk;
      if (l.pclk) begin
        if (l.have && !(l.hen2 && l.h2)) begin
          next_l.dout  = l.word;
          next_l.qual  = 1'b1;
          next_l.have  = 1'b0;
          next_l.ack_t = ~l.ack_t;
        end else begin
          next_l.qual = 1'b0;
        end
      end
      if (l.rq2 != l.rq_seen) begin
        next_l.rq_seen = l.rq2;
        next_l.word    = s.gw;
        next_l.have    = 1'b1;
      end
    end
  end

  // Reset release into the link domain.
  always_ff @(posedge lclk) begin
    lrst <= {lrst[0], rstn};
  end

  // Registers of the link domain.
  always_ff @(posedge lclk) begin
    if (!lrst[1]) l <= '0;
    else l <= next_l;
  end

  // Pin drivers, all straight from link flip-flops.
  assign pin_o = '{data:    l.dout,
                   data_oe: l.oe,
                   clk:     l.pclk,
                   clk_oe:  l.oe,
                   qual:    l.qual,
                   qual_oe: l.oe,
                   hold:    l.hold,
                   hold_oe: l.hoe};

  // ****************************************
  // Assertions
  // ****************************************
  sequence seq_last_ack;
    (s.gst == GS_ACK) && (s.ga2 != s.ga_seen) && s.en && (s.idx == tab[s.ent].len)
      && (s.rep == 8'h00) && (({1'b0, s.ent} + 7'h01) == s.chain);
  endsequence
  sequence seq_trig;
    (s.gst == GS_IDLE) && req.wr && (req.addr == OFS_CTRL) && req.wdata[CTRL_TRIG]
      && req.wdata[CTRL_EN] && s.en && s.strap2 && (s.chain != 7'h00);
  endsequence

  AST_TRIG_START: assert property (@(posedge clk) disable iff (!rstn)
    seq_trig |=> (s.gst == GS_DLY) && (s.ent == 6'h00) && (s.idx == 8'h00))
    else $error("trigger did not start the chain");
  AST_CHAIN_END: assert property (@(posedge clk) disable iff (!rstn)
    seq_last_ack |=> (s.gst == GS_IDLE))
    else $error("chain did not end after last entry");
  AST_CAP_STORE: assert property (@(posedge clk) disable iff (!rstn)
    ((s.cc2 != s.cc_seen) && !full && !s.tdone && !req.wr && !req.rd)
      |=> (s.wptr == $past(s.wptr) + 9'h001))
    else $error("captured word not stored");
  AST_GEN_OE: assert property (@(posedge lclk) disable iff (!lrst[1])
    l.gen2 |=> l.oe ##1 (l.oe || !l.gen2))
    else $error("generation pins not driven");
  AST_CAP_OE: assert property (@(posedge lclk) disable iff (!lrst[1])
    !l.gen2 |=> !l.oe)
    else $error("capture pins driven");
  AST_CAP_QUAL: assert property (@(posedge lclk) disable iff (!lrst[1])
    !(l.q2 && l.en2) |=> $stable(l.cap_t))
    else $error("word taken without qualifier");
  AST_TP_WORD: assert property (@(posedge lclk) disable iff (!lrst[1])
    (!l.gen2 && l.en2 && l.q2 && l.tp2 && !l.busy) |=> (l.cw == $past(l.tpc)))
    else $error("test pattern word wrong");
  AST_HOLD_OUT: assert property (@(posedge lclk) disable iff (!lrst[1])
    (!l.gen2 && l.hen2 && l.full2) |=> l.hold)
    else $error("hold not raised when bank full");
  AST_GEN_CLK: assert property (@(posedge lclk) disable iff (!lrst[1])
    l.gen2 |=> (l.pclk != $past(l.pclk)))
    else $error("port clock not running");
  AST_HELD: assert property (@(posedge lclk) disable iff (!lrst[1])
    (l.gen2 && l.pclk && l.hen2 && l.h2)
      |=> !l.qual && $stable(l.ack_t) && (l.have || !$past(l.have)))
    else $error("word sent while held");
endmodule

// [design/lwc_pkg.sv]
// Constants, register map and state types of the word capture and generation port.
//
// Function
// - Input strap selects capture, port pins inputs; the code drives the hold pin as an output in capture.
// - Capture takes words only while qualifier asserted.
// - Capture may raise hold when it cannot accept.
// - Capture word from pins or test pattern.
// - Each unit owns bank: FIFO or transient record.
// - Captured words leave bank through host reads.
// - Output strap selects generation, port pins driven; the code leaves the hold pin undriven as an input in generation.
// - Generation drives free clock; qualifier marks words.
// - Enabled hold input halts generation.
// - Link controller plays 32-bit words from tables.
// - Entry holds length, trigger delay, repeat count.
// - Up to 64 entries chained in order.
package lwc_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int unsigned DW      = 32;
  localparam int unsigned RAW     = 8;
  localparam int unsigned BAW     = 8;
  localparam int unsigned BDEPTH  = 256;
  localparam int unsigned EAW     = 6;
  localparam int unsigned ENTRIES = 64;

  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [RAW-1:0] OFS_CTRL   = 8'h00;
  localparam logic [RAW-1:0] OFS_STATUS = 8'h04;
  localparam logic [RAW-1:0] OFS_DATA   = 8'h08;
  localparam logic [RAW-1:0] OFS_ESEL   = 8'h0c;
  localparam logic [RAW-1:0] OFS_EBASE  = 8'h10;
  localparam logic [RAW-1:0] OFS_ELEN   = 8'h14;
  localparam logic [RAW-1:0] OFS_EDLY   = 8'h18;
  localparam logic [RAW-1:0] OFS_EREP   = 8'h1c;
  localparam logic [RAW-1:0] OFS_CHAIN  = 8'h20;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int unsigned CTRL_EN    = 0;
  localparam int unsigned CTRL_TP    = 1;
  localparam int unsigned CTRL_HOLD  = 2;
  localparam int unsigned CTRL_TRANS = 3;
  localparam int unsigned CTRL_TRIG  = 4;
  localparam int unsigned CTRL_CLR   = 5;
  localparam int unsigned ST_GEN     = 0;
  localparam int unsigned ST_BUSY    = 1;
  localparam int unsigned ST_FULL    = 2;
  localparam int unsigned ST_EMPTY   = 3;
  localparam int unsigned ST_OVR     = 4;
  localparam int unsigned ST_CNT_LO  = 8;

  // Generation sequencer states.
  typedef enum logic [3:0] {
    GS_IDLE = 4'h1,
    GS_DLY  = 4'h2,
    GS_SEND = 4'h4,
    GS_ACK  = 4'h8
  } lwc_gen_e;

  // One link entry of the generation chain.
  typedef struct packed {
    logic [BAW-1:0] base;
    logic [7:0]     len;
    logic [15:0]    dly;
    logic [7:0]     rep;
  } lwc_ent_s;

  // Software register port request.
  typedef struct packed {
    logic [RAW-1:0] addr;
    logic [DW-1:0]  wdata;
    logic           wr;
    logic           rd;
  } lwc_req_s;

  // Front-panel pins seen from the device.
  typedef struct packed {
    logic [DW-1:0] data;
    logic          clk;
    logic          qual;
    logic          hold;
  } lwc_pin_in_s;

  typedef struct packed {
    logic [DW-1:0] data;
    logic          data_oe;
    logic          clk;
    logic          clk_oe;
    logic          qual;
    logic          qual_oe;
    logic          hold;
    logic          hold_oe;
  } lwc_pin_out_s;

endpackage

// [testbench/lwc_far_end.sv]
// Far-end model: word source in capture mode, word sink in generation mode.
`timescale 1ns/1ps
module lwc_far_end (
  input  wire logic        lclk,
  input  wire logic        pclk,
  input  wire logic [31:0] pdata,
  input  wire logic        pqual,
  input  wire logic        phold,
  input  wire logic        stall_en,
  output logic [31:0]      src_data,
  output logic             src_qual,
  output logic             dst_hold
);
  // ********
  // State
  // ********
  logic [31:0] got[$];
  int          held_words;
  int          pclk_edges;
  int          hold_run;
  bit          hold_seen;

  // Idle lines start low and counters at zero.
  initial begin
    src_data   = 32'h0;
    src_qual   = 1'b0;
    dst_hold   = 1'b0;
    held_words = 0;
    pclk_edges = 0;
    hold_run   = 0;
    hold_seen  = 0;
  end

  // Sends one qualified word after the device drops hold; idle data keeps changing.
  task automatic send(input logic [31:0] d);
    int n;
    n = 0;
    @(posedge lclk);
    while (phold === 1'b1 && n < 200) begin
      @(posedge lclk);
      n++;
    end
    src_qual <= 1'b1;
    src_data <= d;
    @(posedge lclk);
    src_qual <= 1'b0;
    src_data <= ~d;
    repeat (4) begin
      @(posedge lclk);
      src_data <= $urandom;
    end
  endtask

  // Holds the qualifier for n cycles, ignoring hold, to overrun the port.
  task automatic burst(input int n);
    @(posedge lclk);
    src_qual <= 1'b1;
    src_data <= $urandom;
    repeat (n) @(posedge lclk);
    src_qual <= 1'b0;
  endtask

  // Notes any cycle where the device asks the source to stop.
  always @(posedge lclk) begin
    if (phold === 1'b1) hold_seen <= 1;
  end

  // Collects qualified words on the rising port clock; a word under a long hold is a fault.
  always @(posedge pclk) begin
    pclk_edges <= pclk_edges + 1;
    if (pqual === 1'b1) begin
      got.push_back(pdata);
      if (hold_run > 10) held_words <= held_words + 1;
    end
  end

  // Stalls the device at random while stalling is enabled.
  always @(posedge lclk) begin
    if (!stall_en) dst_hold <= 1'b0;
    else if ($urandom_range(7) == 0) dst_hold <= ~dst_hold;
    hold_run <= dst_hold ? hold_run + 1 : 0;
  end
endmodule

// [testbench/lwc_top_test.sv]
// Self-checking bench of the word capture and generation port.
`timescale 1ns/1ps
module lwc_top_test;
  import lwc_pkg::*;
  // ********
  // Signals
  // ********
  logic          clk;
  logic          lclk;
  logic          rstn;
  logic          strap_gen;
  logic          stall_en;
  lwc_req_s      req;
  logic [DW-1:0] rdata;
  lwc_pin_in_s   pin_i;
  lwc_pin_out_s  pin_o;
  logic [31:0]   src_data;
  logic          src_qual;
  logic          dst_hold;
  logic [31:0]   q;
  logic [31:0]   p;
  int            failures;
  int            checks_done;
  int            n;
  logic [31:0]   sent[$];
  logic [31:0]   exp_q[$];
  logic [31:0]   tbl[16];
  lwc_ent_s      ent[ENTRIES];

  // Clocks: the link clock is unrelated in phase to the system clock.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    lclk = 1'b0;
    #3.3;
    forever #6 lclk = ~lclk;
  end

  // Data, qualifier and hold levels come from whichever side enables its driver; the clock pin is the link clock.
  always_comb begin
    pin_i.data = pin_o.data_oe ? pin_o.data : src_data;
    pin_i.clk  = lclk;
    pin_i.qual = pin_o.qual_oe ? pin_o.qual : src_qual;
    pin_i.hold = pin_o.hold_oe ? pin_o.hold : dst_hold;
  end

  lwc_top lwc_top_i (.clk(clk), .rstn(rstn), .lclk(lclk), .strap_gen(strap_gen), .req(req),
    .rdata(rdata), .pin_i(pin_i), .pin_o(pin_o));

  lwc_far_end lwc_far_end_i (.lclk(lclk), .pclk(pin_o.clk & pin_o.clk_oe), .pdata(pin_o.data),
    .pqual(pin_o.qual & pin_o.qual_oe), .phold(pin_o.hold & pin_o.hold_oe),
    .stall_en(stall_en), .src_data(src_data), .src_qual(src_qual), .dst_hold(dst_hold));

  // ********
  // Tasks
  // ********
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req.addr  <= a;
    req.wdata <= d;
    req.wr    <= 1'b1;
    @(posedge clk);
    req.wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe.
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    req.addr <= a;
    req.rd   <= 1'b1;
    @(posedge clk);
    req.rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic do_reset(input logic gen);
    rstn      <= 1'b0;
    strap_gen <= gen;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    repeat (20) @(posedge clk);
  endtask

  // Expected output: entries in order, each table played rep+1 times of len+1 words.
  function automatic void build_expect();
    exp_q.delete();
    for (int e = 0; e < ENTRIES; e++) begin
      for (int r = 0; r <= ent[e].rep; r++) begin
        for (int k = 0; k <= ent[e].len; k++) begin
          exp_q.push_back(tbl[ent[e].base + k]);
        end
      end
    end
  endfunction

  task automatic report_and_stop();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Cuts a hang short.
  initial begin
    #720000;
    failures++;
    report_and_stop();
  end

  // ********
  // Main sequence
  // ********
  initial begin
    failures    = 0;
    checks_done = 0;
    req         = '0;
    rstn        = 1'b0;
    strap_gen   = 1'b0;
    stall_en    = 1'b0;
    void'($urandom(32'he65f));
    // Capture mode: words only where qualified, hold raised, words popped in order.
    do_reset(1'b0);
    rd(OFS_STATUS, q);
    check(32'(q[ST_GEN]), 32'h0);
    check(32'(pin_o.qual_oe), 32'h0);
    check(32'(pin_o.hold_oe), 32'h1);
    wr(OFS_CTRL, 32'h25);
    for (int i = 0; i < 12; i++) begin
      q = $urandom;
      sent.push_back(q);
      lwc_far_end_i.send(q);
    end
    repeat (40) @(posedge clk);
    rd(OFS_STATUS, q);
    check(32'(q[16:8]), 32'(sent.size()));
    check(32'(lwc_far_end_i.hold_seen), 32'h1);
    foreach (sent[i]) begin
      rd(OFS_DATA, q);
      check(q, sent[i]);
    end
    rd(OFS_STATUS, q);
    check(32'(q[ST_EMPTY]), 32'h1);
    rd(OFS_DATA, q);
    check(q, 32'h0);
    rd(8'h40, q);
    check(q, 32'h0);
    // Test pattern source: consecutive captured words count up by one.
    wr(OFS_CTRL, 32'h27);
    repeat (5) lwc_far_end_i.send($urandom);
    repeat (40) @(posedge clk);
    rd(OFS_DATA, p);
    for (int i = 1; i < 5; i++) begin
      rd(OFS_DATA, q);
      check(q, p + 32'h1);
      p = q;
    end
    rd(OFS_CTRL, q);
    check(q, 32'h7);
    // Overrun: a burst while a word is in flight loses words and sets the sticky flag.
    lwc_far_end_i.burst(4);
    repeat (40) @(posedge clk);
    rd(OFS_STATUS, q);
    check(32'(q[ST_OVR]), 32'h1);
    wr(OFS_STATUS, 32'h10);
    rd(OFS_STATUS, q);
    check(32'(q[ST_OVR]), 32'h0);
    // Generation mode: pins driven, clock free running, 64 chained entries under stalls.
    do_reset(1'b1);
    rd(OFS_STATUS, q);
    check(32'(q[ST_GEN]), 32'h1);
    check(32'({pin_o.data_oe, pin_o.clk_oe, pin_o.qual_oe, pin_o.hold_oe}), 32'he);
    n = lwc_far_end_i.pclk_edges;
    repeat (40) @(posedge lclk);
    check(32'(lwc_far_end_i.pclk_edges - n >= 15), 32'h1);
    wr(OFS_CTRL, 32'h20);
    for (int i = 0; i < 16; i++) begin
      tbl[i] = $urandom;
      wr(OFS_DATA, tbl[i]);
    end
    for (int e = 0; e < ENTRIES; e++) begin
      ent[e].base = 8'($urandom_range(13));
      ent[e].len  = 8'($urandom_range(2));
      ent[e].rep  = 8'($urandom_range(1));
      ent[e].dly  = (e == 0) ? 16'd200 : 16'($urandom_range(3));
      wr(OFS_ESEL, 32'(e));
      wr(OFS_EBASE, 32'(ent[e].base));
      wr(OFS_ELEN, 32'(ent[e].len));
      wr(OFS_EDLY, 32'(ent[e].dly));
      wr(OFS_EREP, 32'(ent[e].rep));
    end
    wr(OFS_CHAIN, 32'd64);
    build_expect();
    stall_en <= 1'b1;
    wr(OFS_CTRL, 32'h05);
    wr(OFS_CTRL, 32'h15);
    repeat (150) @(posedge clk);
    check(32'(lwc_far_end_i.got.size()), 32'h0);
    n = 0;
    do begin
      rd(OFS_STATUS, q);
      n++;
    end while (q[ST_BUSY] !== 1'b0 && n < 30000);
    check(32'(q[ST_BUSY]), 32'h0);
    repeat (50) @(posedge lclk);
    stall_en <= 1'b0;
    check(32'(lwc_far_end_i.got.size()), 32'(exp_q.size()));
    foreach (exp_q[i]) begin
      check(lwc_far_end_i.got[i], exp_q[i]);
    end
    check(32'(lwc_far_end_i.held_words), 32'h0);
    report_and_stop();
  end
endmodule
